// file: shared/mode_vec_pkg.sv
package mode_vec_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NSRC   = 23;
    localparam int unsigned NGRP   = 7;
    localparam int unsigned PORT_W = 24;
    localparam int unsigned VNUM_W = 7;
    localparam int unsigned CNT_W  = 3;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFS_SYS_CTRL  = 8'h04;
    localparam logic [7:0] OFS_DDR       = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
    localparam logic [7:0] OFS_PRIO_CTRL = 8'h14;
    localparam logic [7:0] OFS_VECTOR    = 8'h18;

    // Field positions
    localparam int unsigned EXTERNAL_EXPANSION_ENABLE_BIT = 0;
    localparam int unsigned IOS_BIT  = 1;
    localparam int unsigned ONCHIP_RAM_ENABLE_BIT = 0;

    // Values after reset
    localparam logic RST_EXTERNAL_EXPANSION_ENABLE = 1'b0;
    localparam logic RST_IOS  = 1'b0;
    localparam logic RST_ONCHIP_RAM_ENABLE = 1'b1;

    // ==========================================================
    // Timing: mode pins settle through the synchroniser
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned SAMPLE_TIME_NS = 400;
    localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(
        (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_NONE,
        MODE_1,
        MODE_2,
        MODE_3
    } mode_t;

    typedef enum logic {
        ST_SAMPLE,
        ST_RUN
    } fsm_t;

    // ==========================================================
    // Source index to vector number
    function automatic logic [6:0] src_vec(input int unsigned i);
        case (i)
            0, 1, 2:         src_vec = 7'(64 + i); // RQ11
            3, 4:            src_vec = 7'(73 + i); // RQ13
            20, 21, 22:      src_vec = 7'(76 + i); // RQ15
            default:         src_vec = 7'(75 + i); // RQ12 RQ14
        endcase
    endfunction : src_vec

    // Source index to priority-control group
    function automatic int unsigned src_grp(input int unsigned i);
        if (i < 3)
            src_grp = 0;
        else if (i < 5 || i > 19)
            src_grp = 1;
        else if (i < 17)
            src_grp = 2 + (i - 5) / 4;
        else if (i < 19)
            src_grp = 5;
        else
            src_grp = 6;
    endfunction : src_grp

    // Vector table address from vector number
    function automatic logic [23:0] vec_addr(input logic [6:0] n,
                                             input logic       adv);
        vec_addr = adv ? {15'h0000, n, 2'b00} : {16'h0000, n, 1'b0};
    endfunction : vec_addr

endpackage : mode_vec_pkg

// file: logic/pin_sync3.sv
`timescale 1ns/100ps

module pin_sync3 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    // ==========================================================
    // A change counts only once stages two and three agree
    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pin_i;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        if (s_reg.s2 == s_reg.s3) begin
            s_next.q = s_reg.s3;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_o = s_reg.q;

endmodule : pin_sync3

// file: logic/vec_pick.sv
`timescale 1ns/100ps

module vec_pick (
    input  wire logic [mode_vec_pkg::NSRC-1:0] pend_i,
    input  wire logic [mode_vec_pkg::NGRP-1:0] prio_i,
    output logic                               found_o,
    output logic [mode_vec_pkg::VNUM_W-1:0]    vnum_o
);
    import mode_vec_pkg::*;

    logic [NSRC-1:0] hi;
    logic [NSRC-1:0] use_set;

    // ==========================================================
    // Sources whose group has its priority-control bit set
    for (genvar g = 0; g < NSRC; g++) begin : g_hi
        assign hi[g] = pend_i[g] & prio_i[src_grp(g)]; // RQ11 RQ12
    end

    // Raised groups beat default ones; then lowest vector wins
    always_comb begin
        use_set = (|hi) ? hi : pend_i;
        found_o = |pend_i;
        vnum_o  = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (use_set[i]) begin
                vnum_o = src_vec(i); // RQ11
            end
        end
    end

endmodule : vec_pick

// file: logic/mode_vector_ctrl.sv
`timescale 1ns/100ps

// Function
// RQ1 - Mode pins pick modes one to three
// RQ2 - Mode one: normal 64k, ROM disabled
// RQ3 - Mode one: ports carry address, data, control
// RQ4 - Mode two: advanced 16M, ROM enabled
// RQ5 - Modes two/three start single-chip until enabled
// RQ6 - Expanded address pins follow direction bits
// RQ7 - Reduced pins: mode two needs strobe function
// RQ8 - Mode three: normal, ROM limited 56k
// RQ9 - RAM disabled sends its range external
// RQ10 - Vector address: two or four bytes
// RQ11 - Timer zero vectors 64 to 66
// RQ12 - Serial channels at 80, 84, 88
// RQ13 - Host input full at 76, 77
// RQ14 - Two-wire sources at 92, 93, 94
// RQ15 - Keyboard at 96 to 98, reserved unused
// RQ16 - Mode sampled at reset, then held
module mode_vector_ctrl (
    input  wire logic                              clk_sys_i,
    input  wire logic                              arst_n_i,
    input  wire logic                              mode_select_pin_hi_i,
    input  wire logic                              mode_select_pin_lo_i,
    input  wire logic                              reduced_variant_i,
    input  wire logic [mode_vec_pkg::ADDR_W-1:0]   reg_addr_i,
    input  wire logic [mode_vec_pkg::DATA_W-1:0]   reg_wdata_i,
    input  wire logic                              reg_wr_i,
    input  wire logic                              reg_rd_i,
    output logic      [mode_vec_pkg::DATA_W-1:0]   reg_rdata_o,
    input  wire logic [mode_vec_pkg::NSRC-1:0]     irq_src_i,
    output logic                                   mode_valid_o,
    output logic      [1:0]                        mode_code_o,
    output logic                                   cpu_advanced_o,
    output logic                                   rom_enable_o,
    output logic                                   rom_limit_56k_o,
    output logic                                   ext_expanded_o,
    output logic      [mode_vec_pkg::PORT_W-1:0]   addr_oe_o,
    output logic                                   data_bus_en_o,
    output logic                                   data_bus_hi_en_o,
    output logic                                   bus_ctrl_en_o,
    output logic                                   ext_addr_ok_o,
    output logic                                   ram_external_o,
    output logic                                   vector_valid_o,
    output logic      [mode_vec_pkg::VNUM_W-1:0]   vector_num_o,
    output logic      [23:0]                       vector_addr_o,
    output logic                                   irq_o
);
    import mode_vec_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        fsm_t              fsm;
        logic [CNT_W-1:0]  cnt;
        mode_t             mode;
        logic              reduced;
        logic              external_expansion_enable;
        logic              ios;
        logic              onchip_ram_enable;
        logic [PORT_W-1:0] ddr;
        logic [NSRC-1:0]   stat;
        logic [NSRC-1:0]   mask;
        logic [NGRP-1:0]   prio;
        logic [DATA_W-1:0] rdata;
        logic              vvalid;
        logic [VNUM_W-1:0] vnum;
        logic [23:0]       vaddr;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic [1:0]        pins_q;
    logic              reduced_q;
    logic [NSRC-1:0]   pend;
    logic              pick_found;
    logic [VNUM_W-1:0] pick_vnum;
    logic              adv;
    logic              wr_mode;
    logic              wr_sys;

    // ==========================================================
    // Pin synchronisers: straps come from outside the clock
    pin_sync3 #(
        .W (3)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .pin_i     ({mode_select_pin_hi_i, mode_select_pin_lo_i,
                     reduced_variant_i}),
        .pin_o     ({pins_q, reduced_q})
    );

    // ==========================================================
    // Interrupt vector selection
    assign pend = s_reg.stat & s_reg.mask;

    vec_pick u_pick (
        .pend_i  (pend),
        .prio_i  (s_reg.prio),
        .found_o (pick_found),
        .vnum_o  (pick_vnum)
    );

    assign adv     = (s_reg.mode == MODE_2);
    assign wr_mode = reg_wr_i && (reg_addr_i == OFS_MODE_CTRL);
    assign wr_sys  = reg_wr_i && (reg_addr_i == OFS_SYS_CTRL);

    // ==========================================================
    // Next state
    always_comb begin
        s_next = s_reg;

        // Mode latched once after reset, never while running
        case (s_reg.fsm)
            ST_SAMPLE: begin
                if (s_reg.cnt == SAMPLE_CYC) begin
                    s_next.fsm     = ST_RUN;
                    s_next.mode    = mode_t'(pins_q); // RQ1 RQ16
                    s_next.reduced = reduced_q;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_W'(1);
                end
            end
            ST_RUN: begin
                s_next.fsm = ST_RUN; // RQ16
            end
            default: begin
                s_next.fsm = ST_SAMPLE;
            end
        endcase

        // Register writes
        if (wr_mode) begin
            s_next.external_expansion_enable = reg_wdata_i[EXTERNAL_EXPANSION_ENABLE_BIT]; // RQ5
            s_next.ios  = reg_wdata_i[IOS_BIT];
        end
        if (wr_sys) begin
            s_next.onchip_ram_enable = reg_wdata_i[ONCHIP_RAM_ENABLE_BIT]; // RQ9
        end
        if (reg_wr_i && reg_addr_i == OFS_DDR) begin
            s_next.ddr = reg_wdata_i[PORT_W-1:0];
        end
        if (reg_wr_i && reg_addr_i == OFS_IRQ_MASK) begin
            s_next.mask = reg_wdata_i[NSRC-1:0];
        end
        if (reg_wr_i && reg_addr_i == OFS_PRIO_CTRL) begin
            s_next.prio = reg_wdata_i[NGRP-1:0];
        end

        // Sticky status: a new event beats a same-cycle clear
        s_next.stat = s_reg.stat | irq_src_i;
        if (reg_wr_i && reg_addr_i == OFS_IRQ_STAT) begin
            s_next.stat = (s_reg.stat & ~reg_wdata_i[NSRC-1:0])
                        | irq_src_i;
        end

        // Read data stands for one cycle only
        s_next.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_MODE_CTRL: s_next.rdata = DATA_W'({s_reg.mode,
                                   s_reg.reduced, s_reg.ios,
                                   s_reg.external_expansion_enable});
                OFS_SYS_CTRL:  s_next.rdata = DATA_W'(s_reg.onchip_ram_enable);
                OFS_DDR:       s_next.rdata = DATA_W'(s_reg.ddr);
                OFS_IRQ_STAT:  s_next.rdata = DATA_W'(s_reg.stat);
                OFS_IRQ_MASK:  s_next.rdata = DATA_W'(s_reg.mask);
                OFS_PRIO_CTRL: s_next.rdata = DATA_W'(s_reg.prio);
                OFS_VECTOR:    s_next.rdata = {s_reg.vvalid,
                                   s_reg.vnum, s_reg.vaddr};
                default:       s_next.rdata = '0;
            endcase
        end

        // Vector number and table address of the winner
        s_next.vvalid = pick_found;
        s_next.vnum   = pick_vnum;
        s_next.vaddr  = vec_addr(pick_vnum, adv); // RQ10
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg      <= '0;
            s_reg.fsm  <= ST_SAMPLE;
            s_reg.mode <= MODE_NONE;
            s_reg.external_expansion_enable <= RST_EXTERNAL_EXPANSION_ENABLE;
            s_reg.ios  <= RST_IOS;
            s_reg.onchip_ram_enable <= RST_ONCHIP_RAM_ENABLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Mode decode to CPU, memory and port configuration
    always_comb begin
        mode_valid_o     = (s_reg.mode != MODE_NONE);
        mode_code_o      = 2'(s_reg.mode);
        cpu_advanced_o   = adv; // RQ4
        rom_enable_o     = (s_reg.mode == MODE_2)
                        || (s_reg.mode == MODE_3); // RQ2 RQ4 RQ8
        rom_limit_56k_o  = (s_reg.mode == MODE_3); // RQ8
        ext_expanded_o   = (s_reg.mode == MODE_1)
                        || (rom_enable_o && s_reg.external_expansion_enable); // RQ5
        addr_oe_o        = '0;
        case (s_reg.mode)
            MODE_1: begin
                addr_oe_o[15:0] = 16'hffff; // RQ3
            end
            MODE_2, MODE_3: begin
                if (s_reg.external_expansion_enable) begin
                    addr_oe_o[15:0] = s_reg.ddr[15:0]; // RQ6
                end
                // Upper port exists only on the full-pin part
                if (s_reg.external_expansion_enable && adv && !s_reg.reduced) begin
                    addr_oe_o[23:16] = s_reg.ddr[23:16]; // RQ7
                end
            end
            default: begin
                addr_oe_o = '0;
            end
        endcase
        data_bus_en_o    = ext_expanded_o; // RQ3 RQ6
        data_bus_hi_en_o = ext_expanded_o && !s_reg.reduced;
        bus_ctrl_en_o    = ext_expanded_o;
        // Sixteen address lines cannot reach a 16M space alone
        ext_addr_ok_o    = ext_expanded_o
                        && !(adv && s_reg.reduced && !s_reg.ios); // RQ7
        ram_external_o   = !s_reg.onchip_ram_enable; // RQ9
    end

    // ==========================================================
    // Register-driven outputs
    assign reg_rdata_o    = s_reg.rdata;
    assign vector_valid_o = s_reg.vvalid;
    assign vector_num_o   = s_reg.vnum;
    assign vector_addr_o  = s_reg.vaddr;
    assign irq_o          = |pend;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    mode_latch_a: assert property ( // RQ1
        (s_reg.fsm == ST_SAMPLE && s_next.fsm == ST_RUN)
        |=> mode_code_o == $past(pins_q))
        else $error("mode code differs from sampled pins");

    mode_held_a: assert property ( // RQ16
        (s_reg.fsm == ST_RUN) |=> $stable(mode_code_o)
                                 && s_reg.fsm == ST_RUN)
        else $error("mode changed while running");

    mode1_cfg_a: assert property ( // RQ2
        (s_reg.mode == MODE_1) |-> !cpu_advanced_o && !rom_enable_o)
        else $error("mode one cpu or rom wrong");

    mode1_ports_a: assert property ( // RQ3
        (s_reg.mode == MODE_1) |-> addr_oe_o == 24'h00_ffff
                                   && data_bus_en_o && bus_ctrl_en_o)
        else $error("mode one bus ports wrong");

    mode2_cfg_a: assert property ( // RQ4
        (s_reg.mode == MODE_2) |-> cpu_advanced_o && rom_enable_o)
        else $error("mode two cpu or rom wrong");

    single_chip_a: assert property ( // RQ5
        (rom_enable_o && !s_reg.external_expansion_enable) |-> addr_oe_o == '0
                                         && !ext_expanded_o)
        else $error("address out before expansion enable");

    ddr_follow_a: assert property ( // RQ6
        (s_reg.mode == MODE_3 && s_reg.external_expansion_enable && reg_wr_i
         && reg_addr_i == OFS_DDR)
        |=> addr_oe_o == {8'h00, $past(reg_wdata_i[15:0])})
        else $error("address enables ignore direction bits");

    strobe_need_a: assert property ( // RQ7
        (adv && s_reg.reduced && !s_reg.ios) |-> !ext_addr_ok_o
                                   && addr_oe_o[23:16] == 8'h00)
        else $error("reduced part decodes without strobe");

    mode3_cfg_a: assert property ( // RQ8
        (s_reg.mode == MODE_3) |-> rom_enable_o && rom_limit_56k_o
                                   && !cpu_advanced_o)
        else $error("mode three config wrong");

    ram_route_a: assert property ( // RQ9
        (wr_sys && !reg_wdata_i[ONCHIP_RAM_ENABLE_BIT]) |=> ram_external_o)
        else $error("ram range not sent external");

    vec_spacing_a: assert property ( // RQ10
        (vector_valid_o && vector_num_o == 7'h40)
        |-> vector_addr_o == (cpu_advanced_o ? 24'h00_0100
                                             : 24'h00_0080))
        else $error("vector 64 address wrong");

    timer_first_a: assert property ( // RQ11
        (pend[0] && (s_reg.prio[0] || s_reg.prio == '0))
        |=> vector_num_o == 7'h40)
        else $error("timer match a not chosen first");

    // A raised group bit lets serial zero beat the timer sources
    prio_group_a: assert property ( // RQ11
        (s_reg.prio == 7'h04 && pend[5]) |=> vector_num_o == 7'h50)
        else $error("raised priority group not chosen");

    serial_end_a: assert property ( // RQ12
        ($onehot(pend) && pend[8]) |=> vector_num_o == 7'h53)
        else $error("serial zero end vector wrong");

    host_two_a: assert property ( // RQ13
        ($onehot(pend) && pend[4]) |=> vector_num_o == 7'h4d)
        else $error("host register two vector wrong");

    twowire_fmt_a: assert property ( // RQ14
        ($onehot(pend) && pend[18]) |=> vector_num_o == 7'h5d)
        else $error("format switch vector wrong");

    no_reserved_a: assert property ( // RQ15
        vector_valid_o |-> !(vector_num_o inside {7'h43, 7'h4e,
                             7'h4f, 7'h5f, [7'h63:7'h67]}))
        else $error("reserved vector generated");

    set_wins_a: assert property (
        (irq_src_i[0] && reg_wr_i && reg_addr_i == OFS_IRQ_STAT
         && reg_wdata_i[0]) |=> s_reg.stat[0])
        else $error("event lost on same-cycle clear");

    cov_mode2_exp_c: cover property (
        adv && s_reg.external_expansion_enable && addr_oe_o[23:16] != 8'h00);
    cov_kbd_vec_c: cover property (
        vector_valid_o && vector_num_o == 7'h62);
    cov_irq_clear_c: cover property (
        irq_o ##1 (reg_wr_i && reg_addr_i == OFS_IRQ_STAT) ##1 !irq_o);

endmodule : mode_vector_ctrl

// file: verification/ext_event_model.sv
`timescale 1ns/100ps

// ==========================================================
// Peripheral event sources on the far side of the block
module ext_event_model (
    input  wire logic                          clk_sys_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          fire_i,
    input  wire logic [4:0]                    idx_i,
    output logic      [mode_vec_pkg::NSRC-1:0] irq_src_o
);
    import mode_vec_pkg::*;

    // One-cycle pulse; a held level would re-set status after a clear
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_src_o <= '0;
        end else begin
            irq_src_o <= fire_i ? NSRC'(1) << idx_i : '0;
        end
    end
endmodule : ext_event_model

// file: verification/tb.sv
`timescale 1ns/100ps

module tb;
    import mode_vec_pkg::*;

    // ==========================================================
    // Signals
    logic              clk_sys_i = 1'b0;
    logic              arst_n_i  = 1'b0;
    logic              pin_hi = 1'b0, pin_lo = 1'b0, reduced = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rd_val;
    logic              reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0;
    logic [4:0]        idx = '0;
    logic [NSRC-1:0]   irq_src;
    logic              mvalid, adv, rom, rom56, exp_on, dat, dat_hi;
    logic              ctl, aok, ram_ext, vvalid, irq;
    logic [1:0]        mcode;
    logic [PORT_W-1:0] aoe;
    logic [VNUM_W-1:0] vnum;
    logic [23:0]       vaddr;
    int                num_errors = 0, samples_checked = 0;

    // Half period of the 10 MHz clock
    always #50 clk_sys_i = ~clk_sys_i;

    mode_vector_ctrl DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .mode_select_pin_hi_i(pin_hi), .mode_select_pin_lo_i(pin_lo),
        .reduced_variant_i(reduced), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .irq_src_i(irq_src),
        .mode_valid_o(mvalid), .mode_code_o(mcode), .cpu_advanced_o(adv),
        .rom_enable_o(rom), .rom_limit_56k_o(rom56), .ext_expanded_o(exp_on),
        .addr_oe_o(aoe), .data_bus_en_o(dat), .data_bus_hi_en_o(dat_hi),
        .bus_ctrl_en_o(ctl), .ext_addr_ok_o(aok), .ram_external_o(ram_ext),
        .vector_valid_o(vvalid), .vector_num_o(vnum),
        .vector_addr_o(vaddr), .irq_o(irq));

    ext_event_model u_events (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .fire_i(fire), .idx_i(idx), .irq_src_o(irq_src));

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd

    // Pins are held from reset until well past the latch edge
    task automatic start(input logic hi, input logic lo, input logic red);
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        pin_hi   <= hi;
        pin_lo   <= lo;
        reduced  <= red;
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (7) @(posedge clk_sys_i);
        #1;
    endtask : start

    // Event pulse; returns just after status has been set
    task automatic pulse(input logic [4:0] k);
        @(posedge clk_sys_i);
        fire <= 1'b1;
        idx  <= k;
        @(posedge clk_sys_i);
        fire <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask : pulse

    // ==========================================================
    // Scenarios
    task automatic test_mode1;
        logic [6:0] v;
        start(1'b0, 1'b1, 1'b0);
        check("mode", {mvalid, mcode, adv, rom}, 32'h0000_0014);
        check("port enables", {aoe, dat, dat_hi, ctl, exp_on},
              32'h000f_ffff);
        check("ram route", ram_ext, 32'h0000_0000);
        wr(OFS_SYS_CTRL, 32'h0000_0000);
        check("ram route", ram_ext, 32'h0000_0001);
        rd(8'h1c);
        check("unmapped read", rd_val, 32'h0000_0000);
        // Masked source sets status but raises nothing
        pulse(5'h00);
        check("masked irq", irq, 32'h0000_0000);
        wr(OFS_IRQ_STAT, 32'h0000_0001);
        wr(OFS_IRQ_MASK, 32'h007f_ffff);
        // Every source alone, normal spacing of two bytes
        for (int k = 0; k < NSRC; k++) begin
            v = k < 3 ? 7'(64 + k) : k < 5 ? 7'(73 + k) :
                k < 20 ? 7'(75 + k) : 7'(76 + k);
            pulse(5'(k));
            check("irq", irq, 32'h0000_0001);
            @(posedge clk_sys_i);
            #1;
            check("vector", {vvalid, vnum, vaddr},
                {1'b1, v, 16'h0000, v, 1'b0});
            wr(OFS_IRQ_STAT, 32'h0000_0001 << k);
            check("irq cleared", irq, 32'h0000_0000);
        end
    endtask : test_mode1

    task automatic test_mode2;
        start(1'b1, 1'b0, 1'b0);
        check("mode", {mvalid, mcode, adv, rom}, 32'h0000_001b);
        check("single chip", {exp_on, aoe}, 32'h0000_0000);
        wr(OFS_MODE_CTRL, 32'h0000_0001);
        check("expanded", {exp_on, aoe, dat}, 32'h0200_0001);
        wr(OFS_DDR, 32'h0081_0f01);
        check("address enables", aoe, 32'h0081_0f01);
        @(posedge clk_sys_i);
        pin_hi <= 1'b0;
        pin_lo <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        #1;
        check("mode held", mcode, 32'h0000_0002);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        pulse(5'h00);
        @(posedge clk_sys_i);
        #1;
        check("advanced vector", vaddr, 32'h0000_0100);
        rd(OFS_VECTOR);
        check("vector read", rd_val, 32'hc000_0100);
        // Serial group raised: it beats the still pending timer source
        wr(OFS_IRQ_MASK, 32'h0000_0021);
        wr(OFS_PRIO_CTRL, 32'h0000_0004);
        pulse(5'h05);
        @(posedge clk_sys_i);
        #1;
        check("raised vector", {vnum, vaddr}, 32'h5000_0140);
        wr(OFS_PRIO_CTRL, 32'h0000_0000);
        @(posedge clk_sys_i);
        #1;
        check("default vector", vnum, 32'h0000_0040);
    endtask : test_mode2

    task automatic test_reduced;
        start(1'b1, 1'b0, 1'b1);
        wr(OFS_MODE_CTRL, 32'h0000_0001);
        check("decode ok", aok, 32'h0000_0000);
        wr(OFS_MODE_CTRL, 32'h0000_0003);
        check("decode ok", aok, 32'h0000_0001);
        wr(OFS_DDR, 32'h00ff_ffff);
        check("address enables", {aoe, dat_hi}, 32'h0001_fffe);
    endtask : test_reduced

    task automatic test_mode3_0;
        start(1'b1, 1'b1, 1'b0);
        check("mode", {mvalid, mcode, adv, rom, rom56, exp_on},
              32'h0000_0076);
        wr(OFS_MODE_CTRL, 32'h0000_0001);
        wr(OFS_DDR, 32'h00ab_1234);
        check("mode three enables", {exp_on, aoe}, 32'h0100_1234);
        start(1'b0, 1'b0, 1'b0);
        check("no mode", {mvalid, rom, exp_on}, 32'h0000_0000);
    endtask : test_mode3_0

    // ==========================================================
    // Verdict and run control
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    initial begin
        test_mode1();
        test_mode2();
        test_reduced();
        test_mode3_0();
        results();
    end

    // Whole run needs under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        num_errors++;
        results();
    end
endmodule : tb
